/* bfd_map.vh */
// Address map, field positions, reset values and timing figures of the bridge
// fault and diagnostic control block. Definitions only; included by bare name.
`ifndef BFD_MAP_VH
`define BFD_MAP_VH

// Clock period of clk_in in ns.
`define BFD_CLK_NS 10

// Register indices on the plain register port.
`define BFD_ADR_DIAG_CFG  4'h0
`define BFD_ADR_OCP_CFG   4'h1
`define BFD_ADR_MIRROR    4'h2
`define BFD_ADR_CMD       4'h3
`define BFD_ADR_SUMMARY   4'h4
`define BFD_ADR_ACT_STAT  4'h5
`define BFD_ADR_STBY_STAT 4'h6
`define BFD_ADR_IRQ_STAT  4'h7
`define BFD_ADR_IRQ_MASK  4'h8

// Field positions.
`define BFD_DIAG_SEL_LSB  0
`define BFD_DIAG_INDEP    2
`define BFD_DIAG_LATCH    3
`define BFD_OCP_LVL_LSB   0
`define BFD_OCP_FILT_LSB  2
`define BFD_MIR_IN1       0
`define BFD_MIR_IN2       1
`define BFD_MIR_DRVOFF    2
`define BFD_MIR_UNLOCK    3
`define BFD_CMD_CLR       0

// Reset values.
`define BFD_RST_DIAG_CFG  8'h00
`define BFD_RST_OCP_CFG   8'h00
`define BFD_RST_MIRROR    8'h00
`define BFD_RST_IRQ_MASK  8'h00

// Timing figures in ns.
`define BFD_T_OCP_F0_NS   600
`define BFD_T_OCP_F1_NS   1200
`define BFD_T_OCP_F2_NS   2400
`define BFD_T_OCP_F3_NS   6000
`define BFD_T_TSD_NS      20000
`define BFD_T_RETRY_NS    4000000
`define BFD_T_CLR_TSD_NS  100000

`endif

/* bfd_filt.v */
// Deglitch timer: raises its output once its input level has stood high for
// a programmable number of clock cycles. Assumes one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none

module bfd_filt #(
  parameter W = 20
) (
  // Clock and reset
  input  wire         clk_in,
  input  wire         resetn_in,
  // Level to filter and required duration
  input  wire         level_in,
  input  wire [W-1:0] limit_in,
  // Filtered level
  output reg          done_out
);

  reg [W-1:0] count;
  wire [W-1:0] next_count = count + {{(W-1){1'b0}}, 1'b1};

  always @(posedge clk_in) begin
    if (!resetn_in || !level_in) begin
      count    <= {W{1'b0}};
      done_out <= 1'b0;
    end else if (!done_out) begin
      count <= next_count;
      if (next_count >= limit_in) begin
        done_out <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* bfd_core.v */
// Fault and diagnostic control of an H-bridge driver: diagnostic selection
// decode, overcurrent and over-temperature reactions, fault logging, the
// open-drain fault pin and off-state load check setup.
// Assumes analog comparators arrive already synchronous to clk_in and that
// the device state machine outside provides the active and standby levels.
//
// Contract
// (R1) Full-bridge control: diag_select 00 turns off-state checks off, else on.
// (R2) Independent control: diag_select picks load side, off-state, on-state, sensing.
// (R3) diag_select writes act at once, in any state.
// (R4) Faults pull fault_out_low low; sleep releases it.
// (R5) Serial variant: pin is inverse of summary bit, except locked off-state case.
// (R6) Fault records cleared only by clear_faults_cmd or sleep request.
// (R7) One status read per state gives the whole, uniquely coded picture.
// (R8) Overcurrent_trip only in active state after current exceeds filter time.
// (R9) Overcurrent_trip asserts pin, tri-states both or only affected output.
// (R10) Overcurrent_trip reaction is latched or retry after retry time.
// (R11) Overcurrent level and filter time come from overcurrent_config_reg.
// (R12) Overtemp_shutdown in standby or active: pin, outputs and sense tri-stated.
// (R13) Offstate_load_check runs only in standby with power transistors off.
// (R14) Check setup from pins, or from unlocked spi_input_mirror bits.
// (R15) Hardwired variant routes the comparator to the pin when checks enabled.
// (R16) Serial variant reports comparator in status; on pin when mirror locked.
// (R17) Host steps every setup and samples the comparator after settling.
// (R18) diag_select is two bits of diag_config_reg.
// (R19) Logged bits stay set after the condition clears until cleared.
`timescale 1ns/10ps
`default_nettype none
`include "bfd_map.vh"

module bfd_core #(
  parameter RETRY_CYCLES     = (`BFD_T_RETRY_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS,
  parameter TSD_CLEAR_CYCLES = (`BFD_T_CLR_TSD_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS
) (
  // Clock and reset
  input  wire       clk_in,
  input  wire       resetn_in,
  // Register port
  input  wire [3:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  // Device context
  input  wire       variant_serial_in,
  input  wire       hw_offstate_en_in,
  input  wire       state_active_in,
  input  wire       state_standby_in,
  input  wire       sleep_request_low_in,
  // Controller input pins
  input  wire       ctrl_in1_in,
  input  wire       ctrl_in2_in,
  input  wire       drive_off_in,
  // Analog monitors
  input  wire [1:0] overcurrent_raw_in,
  input  wire       overtemp_raw_in,
  input  wire       offstate_comparator_in,
  // Open-drain fault pin
  input  wire       fault_pin_in,
  output reg        fault_out_low_out,
  output reg        fault_oe_out,
  // Power stage control
  output reg        out1_hiz_out,
  output reg        out2_hiz_out,
  output reg        current_sense_hiz_out,
  output reg  [1:0] ocp_level_out,
  output reg        load_high_side_out,
  output reg        onstate_diag_en_out,
  // Off-state check setup
  output reg        olp_pu1_out,
  output reg        olp_pd1_out,
  output reg        olp_pu2_out,
  output reg        olp_pd2_out,
  output reg        olp_ref_high_out,
  output reg        olp_sel_out2_out,
  // Interrupt
  output reg        irq_out
);

  localparam OCP_F0_CYC = (`BFD_T_OCP_F0_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS;
  localparam OCP_F1_CYC = (`BFD_T_OCP_F1_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS;
  localparam OCP_F2_CYC = (`BFD_T_OCP_F2_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS;
  localparam OCP_F3_CYC = (`BFD_T_OCP_F3_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS;
  localparam TSD_CYC    = (`BFD_T_TSD_NS + `BFD_CLK_NS - 1) / `BFD_CLK_NS;

  reg  [7:0] diag_config_reg;
  reg  [7:0] overcurrent_config_reg;
  reg  [7:0] spi_input_mirror;
  reg  [7:0] irq_stat;
  reg  [7:0] irq_mask;
  reg  [1:0] ocp_trip;
  reg        tsd_trip;
  reg  [1:0] log_ocp;
  reg        log_tsd;
  reg        cmp_prev;
  reg  [19:0] ocp_limit;
  reg        offstate_en_ser;
  reg        load_hs;
  reg        onstate_en;
  reg        sense_en;
  reg        next_pu1;
  reg        next_pd1;
  reg        next_pu2;
  reg        next_pd2;
  reg        next_refh;
  reg        next_sel2;

  wire [1:0] diag_select = diag_config_reg[`BFD_DIAG_SEL_LSB +: 2];
  wire       indep       = diag_config_reg[`BFD_DIAG_INDEP];
  wire       latch_mode  = diag_config_reg[`BFD_DIAG_LATCH];
  wire       unlocked    = spi_input_mirror[`BFD_MIR_UNLOCK];
  wire       asleep      = ~sleep_request_low_in;
  wire       wr_cmd      = reg_wr_in && (reg_addr_in == `BFD_ADR_CMD);
  wire       clear_faults_cmd = wr_cmd && reg_wdata_in[`BFD_CMD_CLR];
  wire       log_clear   = clear_faults_cmd || asleep; // R6
  wire [1:0] ocp_det;
  wire [1:0] ocp_ret;
  wire       tsd_det;
  wire       tsd_ret;

  // Diagnostic selection decode; purely combinational so writes act at once.
  always @* begin
    offstate_en_ser = 1'b0;
    load_hs         = 1'b0;
    onstate_en      = 1'b1;
    sense_en        = 1'b1;
    if (!indep) begin
      offstate_en_ser = (diag_select != 2'b00); // R1
    end else begin
      case (diag_select) // R2
        2'b00: begin
          onstate_en = 1'b0;
        end
        2'b01: begin
          offstate_en_ser = 1'b1;
          onstate_en      = 1'b0;
        end
        2'b10: begin
          load_hs  = 1'b1;
          sense_en = 1'b0;
        end
        default: begin
          offstate_en_ser = 1'b1;
          load_hs         = 1'b1;
          sense_en        = 1'b0;
        end
      endcase
    end
  end

  wire offstate_en = variant_serial_in ? offstate_en_ser : hw_offstate_en_in;

  // Overcurrent filter time from the configuration field.
  always @* begin
    case (overcurrent_config_reg[`BFD_OCP_FILT_LSB +: 2]) // R11
      2'b00:   ocp_limit = OCP_F0_CYC[19:0];
      2'b01:   ocp_limit = OCP_F1_CYC[19:0];
      2'b10:   ocp_limit = OCP_F2_CYC[19:0];
      default: ocp_limit = OCP_F3_CYC[19:0];
    endcase
  end

  // One filter and one retry timer per half-bridge.
  genvar h;
  generate
    for (h = 0; h < 2; h = h + 1) begin : g_half
      bfd_filt #(
        .W (20)
      ) u_ocp_filt (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .level_in  (state_active_in & overcurrent_raw_in[h] & ~ocp_trip[h]), // R8
        .limit_in  (ocp_limit),
        .done_out  (ocp_det[h])
      );
      bfd_filt #(
        .W (20)
      ) u_ocp_retry (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .level_in  (ocp_trip[h] & ~latch_mode), // R10
        .limit_in  (RETRY_CYCLES[19:0]),
        .done_out  (ocp_ret[h])
      );
    end
  endgenerate

  bfd_filt #(
    .W (20)
  ) u_tsd_filt (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .level_in  ((state_active_in | state_standby_in) & overtemp_raw_in & ~tsd_trip), // R12
    .limit_in  (TSD_CYC[19:0]),
    .done_out  (tsd_det)
  );

  // Retry after over-temperature waits for the sensor to fall below its
  // hysteresis point and then for the clear time.
  bfd_filt #(
    .W (20)
  ) u_tsd_clear (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .level_in  (tsd_trip & ~overtemp_raw_in & ~latch_mode), // R12
    .limit_in  (TSD_CLEAR_CYCLES[19:0]),
    .done_out  (tsd_ret)
  );

  // Trip states: a fresh detection wins over a retry or a clear.
  always @(posedge clk_in) begin
    if (!resetn_in || asleep) begin
      ocp_trip <= 2'h0;
      tsd_trip <= 1'b0;
    end else begin
      ocp_trip <= (ocp_trip & ~ocp_ret & ~{2{clear_faults_cmd}}) | ocp_det; // R9 R10
      tsd_trip <= (tsd_trip & ~tsd_ret & ~clear_faults_cmd) | tsd_det; // R12
    end
  end

  // Sticky fault log; detection wins over a clear in the same cycle.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      log_ocp <= 2'h0;
      log_tsd <= 1'b0;
    end else begin
      log_ocp <= (log_ocp & ~{2{log_clear}}) | ocp_det; // R6 R19
      log_tsd <= (log_tsd & ~log_clear) | tsd_det; // R6 R19
    end
  end

  wire summary_fault = |log_ocp | log_tsd;

  // Off-state check setup source and run condition.
  wire use_mirror = variant_serial_in & unlocked;
  wire src_in1 = use_mirror ? spi_input_mirror[`BFD_MIR_IN1] : ctrl_in1_in; // R14
  wire src_in2 = use_mirror ? spi_input_mirror[`BFD_MIR_IN2] : ctrl_in2_in; // R14
  wire src_off = use_mirror ? spi_input_mirror[`BFD_MIR_DRVOFF] : drive_off_in; // R14
  wire olp_run = state_standby_in & offstate_en & src_off & ~asleep; // R13

  always @* begin
    next_pu1  = 1'b0;
    next_pd1  = 1'b0;
    next_pu2  = 1'b0;
    next_pd2  = 1'b0;
    next_refh = 1'b0;
    next_sel2 = 1'b0;
    if (olp_run && !indep) begin
      case ({src_in1, src_in2}) // R14
        2'b10: begin
          next_pu1  = 1'b1;
          next_pd2  = 1'b1;
          next_refh = 1'b1;
        end
        2'b01: begin
          next_pu1  = 1'b1;
          next_pd2  = 1'b1;
          next_sel2 = 1'b1;
        end
        2'b11: begin
          next_pd1  = 1'b1;
          next_pu2  = 1'b1;
          next_sel2 = 1'b1;
        end
        default: begin
          next_sel2 = 1'b0;
        end
      endcase
    end else if (olp_run) begin
      // Upper bit of diag_select picks pull-down with low reference.
      if (src_in1) begin
        next_pu1  = ~diag_select[1];
        next_pd1  = diag_select[1];
        next_refh = ~diag_select[1];
      end else if (src_in2) begin
        next_pu2  = ~diag_select[1];
        next_pd2  = diag_select[1];
        next_refh = ~diag_select[1];
        next_sel2 = 1'b1;
      end
    end
  end

  // Comparator reaches the pin when checks are enabled in standby; in the serial variant only with the mirror locked.
  wire cmp_on_pin = offstate_en & state_standby_in &
                    (variant_serial_in ? ~unlocked : 1'b1); // R15 R16
  wire active_fault = |ocp_trip | tsd_trip;
  wire pin_fault = variant_serial_in ? summary_fault : active_fault; // R5
  wire drive_low = ~asleep & (cmp_on_pin ? offstate_comparator_in : pin_fault); // R4

  // Outputs, all from flops.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      fault_out_low_out     <= 1'b0;
      fault_oe_out          <= 1'b0;
      out1_hiz_out          <= 1'b0;
      out2_hiz_out          <= 1'b0;
      current_sense_hiz_out <= 1'b0;
      ocp_level_out         <= 2'h0;
      load_high_side_out    <= 1'b0;
      onstate_diag_en_out   <= 1'b0;
      olp_pu1_out           <= 1'b0;
      olp_pd1_out           <= 1'b0;
      olp_pu2_out           <= 1'b0;
      olp_pd2_out           <= 1'b0;
      olp_ref_high_out      <= 1'b0;
      olp_sel_out2_out      <= 1'b0;
    end else begin
      fault_out_low_out     <= 1'b0;
      fault_oe_out          <= drive_low; // R4
      out1_hiz_out          <= tsd_trip | (indep ? ocp_trip[0] : |ocp_trip); // R9
      out2_hiz_out          <= tsd_trip | (indep ? ocp_trip[1] : |ocp_trip); // R9
      current_sense_hiz_out <= tsd_trip | ~sense_en; // R12 R2
      ocp_level_out         <= overcurrent_config_reg[`BFD_OCP_LVL_LSB +: 2]; // R11
      load_high_side_out    <= load_hs;
      onstate_diag_en_out   <= onstate_en & state_active_in; // R1 R2
      olp_pu1_out           <= next_pu1;
      olp_pd1_out           <= next_pd1;
      olp_pu2_out           <= next_pu2;
      olp_pd2_out           <= next_pd2;
      olp_ref_high_out      <= next_refh;
      olp_sel_out2_out      <= next_sel2;
    end
  end

  // Configuration writes take effect on the next edge in any state.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      diag_config_reg        <= `BFD_RST_DIAG_CFG;
      overcurrent_config_reg <= `BFD_RST_OCP_CFG;
      spi_input_mirror       <= `BFD_RST_MIRROR;
      irq_mask               <= `BFD_RST_IRQ_MASK;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `BFD_ADR_DIAG_CFG: diag_config_reg <= reg_wdata_in; // R3 R18
        `BFD_ADR_OCP_CFG:  overcurrent_config_reg <= reg_wdata_in;
        `BFD_ADR_MIRROR:   spi_input_mirror <= reg_wdata_in;
        `BFD_ADR_IRQ_MASK: irq_mask <= reg_wdata_in;
        default: begin
          irq_mask <= irq_mask;
        end
      endcase
    end
  end

  // Interrupt events: overcurrent per half, over-temperature, comparator rise.
  wire       cmp_rise = offstate_comparator_in & ~cmp_prev & state_standby_in;
  wire [7:0] irq_set  = {4'h0, cmp_rise, tsd_det, ocp_det};
  wire [7:0] irq_w1c  = (reg_wr_in && reg_addr_in == `BFD_ADR_IRQ_STAT) ?
                        reg_wdata_in : 8'h00;

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      irq_stat <= 8'h00;
      cmp_prev <= 1'b0;
      irq_out  <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_w1c) | irq_set;
      cmp_prev <= offstate_comparator_in;
      irq_out  <= |(irq_stat & irq_mask);
    end
  end

  // Status words; each fault has its own bit in the active view, the standby view logs only over-temperature.
  wire [7:0] summary_word = {5'h00, log_tsd, |log_ocp, summary_fault};
  wire [7:0] active_word  = {3'h0, onstate_en, summary_fault, log_tsd, log_ocp}; // R7
  wire [7:0] standby_word = {3'h0, ~fault_pin_in, offstate_en, summary_fault,
                             log_tsd, offstate_comparator_in}; // R7 R16

  always @(posedge clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `BFD_ADR_DIAG_CFG:  reg_rdata_out <= diag_config_reg;
        `BFD_ADR_OCP_CFG:   reg_rdata_out <= overcurrent_config_reg;
        `BFD_ADR_MIRROR:    reg_rdata_out <= spi_input_mirror;
        `BFD_ADR_SUMMARY:   reg_rdata_out <= summary_word;
        `BFD_ADR_ACT_STAT:  reg_rdata_out <= active_word;
        `BFD_ADR_STBY_STAT: reg_rdata_out <= standby_word;
        `BFD_ADR_IRQ_STAT:  reg_rdata_out <= irq_stat;
        `BFD_ADR_IRQ_MASK:  reg_rdata_out <= irq_mask;
        default:            reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* bfd_pin_model.sv */
// Far-side model of the open-drain fault line as the host board sees it.
// Assumes an external pull-up and that the core reports its pull-down enable.
`timescale 1ns/10ps
`default_nettype none
module bfd_pin_model (
  // Pull-down request from the core
  input  wire logic fault_oe_in,
  // Resolved line level fed back to the core
  output wire logic fault_pin_out
);
  // Released means the pull-up wins, so the host never reads a stale low.
  assign fault_pin_out = fault_oe_in ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* bfd_core_sva.sv */
// Assertion checker for the bridge fault and diagnostic core.
// Assumes the single clk_in domain and the port timing of the core.
`timescale 1ns/10ps
`default_nettype none
module bfd_core_chk (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       resetn_in,
  // Observed ports
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       variant_serial_in,
  input wire logic       hw_offstate_en_in,
  input wire logic       state_active_in,
  input wire logic       state_standby_in,
  input wire logic       sleep_request_low_in,
  input wire logic [1:0] overcurrent_raw_in,
  input wire logic       overtemp_raw_in,
  input wire logic       offstate_comparator_in,
  input wire logic       fault_out_low_out,
  input wire logic       fault_oe_out,
  input wire logic       out1_hiz_out,
  input wire logic [1:0] ocp_level_out,
  input wire logic       load_high_side_out,
  input wire logic       onstate_diag_en_out,
  input wire logic       olp_pu1_out,
  input wire logic       olp_pd1_out,
  input wire logic       olp_pu2_out,
  input wire logic       olp_pd2_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [7:0] run_cnt;
  // Counts how long a fault cause has stood, so a trip without its filter is caught.
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !((state_active_in && |overcurrent_raw_in) || overtemp_raw_in))
      run_cnt <= 8'h00;
    else if (run_cnt != 8'hFF)
      run_cnt <= run_cnt + 8'h01;
  end
  sequence s_hs_write;
    reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[2:0] == 3'b111;
  endsequence
  sequence s_cmp_route;
    sleep_request_low_in && !variant_serial_in && hw_offstate_en_in && state_standby_in;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  a_pin_only_low: assert property (fault_out_low_out == 1'b0)
    else $error("fault pin driven high");
  a_sleep_release: assert property (!sleep_request_low_in |=> !fault_oe_out)
    else $error("fault pin held during sleep");
  a_trip_after_filter: assert property ($rose(out1_hiz_out) |-> run_cnt >= 8'd60)
    else $error("output tri-stated before filter time");
  a_onstate_active: assert property (onstate_diag_en_out |-> $past(state_active_in))
    else $error("on-state diagnostics outside active state");
  a_olp_standby: assert property ((olp_pu1_out || olp_pd1_out || olp_pu2_out || olp_pd2_out)
    |-> $past(state_standby_in))
    else $error("off-state pull applied outside standby");
  a_cmp_on_pin: assert property (s_cmp_route |=> fault_oe_out == $past(offstate_comparator_in))
    else $error("comparator not routed to fault pin");
  a_ocp_cfg_src: assert property ($changed(ocp_level_out)
    |-> $past(reg_wr_in && reg_addr_in == 4'h1) || $past(reg_wr_in && reg_addr_in == 4'h1, 2))
    else $error("overcurrent level changed without write");
  a_diag_at_once: assert property (s_hs_write |-> ##[1:2] load_high_side_out)
    else $error("diag select write not applied at once");
endmodule
bind bfd_core bfd_core_chk bfd_core_chk_i (.clk_in, .resetn_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .variant_serial_in, .hw_offstate_en_in,
  .state_active_in, .state_standby_in, .sleep_request_low_in, .overcurrent_raw_in,
  .overtemp_raw_in, .offstate_comparator_in, .fault_out_low_out, .fault_oe_out,
  .out1_hiz_out, .ocp_level_out, .load_high_side_out, .onstate_diag_en_out,
  .olp_pu1_out, .olp_pd1_out, .olp_pu2_out, .olp_pd2_out);
`default_nettype wire

/* tb.sv */
// Self-checking bench for the bridge fault and diagnostic core.
// Assumes bfd_core, bfd_pin_model and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic       variant_serial_in = 1'b1;
  logic       hw_offstate_en_in = 1'b0;
  logic       state_active_in = 1'b0;
  logic       state_standby_in = 1'b1;
  logic       sleep_request_low_in = 1'b1;
  logic       ctrl_in1_in = 1'b0;
  logic       ctrl_in2_in = 1'b0;
  logic       drive_off_in = 1'b0;
  logic [1:0] overcurrent_raw_in = 2'b00;
  logic       overtemp_raw_in = 1'b0;
  logic       offstate_comparator_in = 1'b0;
  logic       fault_pin_in;
  logic       fault_oe_out, out1_hiz_out, out2_hiz_out, current_sense_hiz_out;
  logic [1:0] ocp_level_out;
  logic       load_high_side_out, irq_out, onstate_diag_en_out;
  logic [5:0] olp_setup;
  logic [7:0] rdv;
  logic [1:0] sv;
  logic       offen, onst, hs;
  int         errors = 0;
  int         cmp_count = 0;

  // Retry and clear counts are cut to 20 cycles to keep the run short.
  bfd_core #(.RETRY_CYCLES(20'd20), .TSD_CLEAR_CYCLES(20'd20)) bfd_core_i (.clk_in, .resetn_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .variant_serial_in,
    .hw_offstate_en_in, .state_active_in, .state_standby_in, .sleep_request_low_in,
    .ctrl_in1_in, .ctrl_in2_in, .drive_off_in, .overcurrent_raw_in, .overtemp_raw_in,
    .offstate_comparator_in, .fault_pin_in, .fault_out_low_out(), .fault_oe_out,
    .out1_hiz_out, .out2_hiz_out, .current_sense_hiz_out, .ocp_level_out, .load_high_side_out,
    .onstate_diag_en_out, .olp_pu1_out(olp_setup[5]), .olp_pd1_out(olp_setup[4]),
    .olp_pu2_out(olp_setup[3]), .olp_pd2_out(olp_setup[2]), .olp_ref_high_out(olp_setup[1]),
    .olp_sel_out2_out(olp_setup[0]), .irq_out);
  bfd_pin_model bfd_pin_model_i (.fault_oe_in(fault_oe_out), .fault_pin_out(fault_pin_in));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    check({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd_get(input logic [3:0] a);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rdv = reg_rdata_out;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    rd_get(a);
    check(rdv, exp, what);
  endtask

  task automatic set_state(input logic act);
    @(posedge clk_in);
    state_active_in <= act;
    state_standby_in <= !act;
  endtask

  task automatic pulse_ocp(input logic [1:0] v, input int n);
    @(posedge clk_in);
    overcurrent_raw_in <= v;
    repeat (n) @(posedge clk_in);
    overcurrent_raw_in <= 2'b00;
    wait_cyc(2);
  endtask

  initial begin
    #200000;
    errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(4'h0, 8'h00, "diag cfg reset");
    rd(4'h1, 8'h00, "ocp cfg reset");
    rd(4'h2, 8'h00, "mirror reset");
    rd(4'h8, 8'h00, "irq mask reset");
    rd(4'hF, 8'h00, "unmapped read");
    wr(4'h0, 8'h0F);
    rd(4'h0, 8'h0F, "diag cfg write");
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        sv = 2'(s);
        offen = (m != 0) ? sv[0] : (sv != 2'b00);
        hs = (m != 0) && sv[1];
        onst = (m == 0) || sv[1];
        set_state(1'b0);
        wr(4'h0, 8'(m * 4 + s));
        rd(4'h6, {4'h0, offen, 3'b000}, "offstate enable");
        chk1(load_high_side_out, hs, "load side");
        set_state(1'b1);
        wait_cyc(3);
        rd(4'h5, {3'b000, onst, 4'h0}, "onstate enable");
        chk1(current_sense_hiz_out, hs, "sensing off");
        chk1(onstate_diag_en_out, onst, "onstate out");
      end
    end
    $display("test diag select done");
    wr(4'h1, 8'h06);
    wr(4'h8, 8'h01);
    wr(4'h0, 8'h08);
    wait_cyc(2);
    check({6'h00, ocp_level_out}, 8'h02, "ocp level");
    pulse_ocp(2'b01, 100);
    chk1(out1_hiz_out, 1'b0, "filter holds");
    pulse_ocp(2'b01, 130);
    chk1(out2_hiz_out, 1'b1, "both outputs off");
    chk1(fault_oe_out, 1'b1, "pin asserted");
    chk1(irq_out, 1'b1, "irq raised");
    wait_cyc(40);
    chk1(out1_hiz_out, 1'b1, "latched trip");
    rd(4'h4, 8'h03, "summary ocp");
    rd(4'h5, 8'h19, "active status ocp");
    rd(4'h7, 8'h01, "irq status");
    wr(4'h7, 8'h01);
    wait_cyc(2);
    chk1(irq_out, 1'b0, "irq cleared");
    rd(4'h4, 8'h03, "log kept");
    wr(4'h3, 8'h01);
    wait_cyc(3);
    chk1(out1_hiz_out, 1'b0, "clear ends trip");
    chk1(fault_oe_out, 1'b0, "pin released");
    rd(4'h4, 8'h00, "summary cleared");
    wr(4'h0, 8'h00);
    pulse_ocp(2'b01, 130);
    wait_cyc(40);
    chk1(out1_hiz_out, 1'b0, "retry clears");
    rd(4'h4, 8'h03, "log after retry");
    @(posedge clk_in);
    sleep_request_low_in <= 1'b0;
    wait_cyc(3);
    chk1(fault_oe_out, 1'b0, "sleep releases");
    @(posedge clk_in);
    sleep_request_low_in <= 1'b1;
    rd(4'h4, 8'h00, "sleep clears log");
    wr(4'h0, 8'h0C);
    pulse_ocp(2'b10, 130);
    chk1(out2_hiz_out, 1'b1, "half two off");
    chk1(out1_hiz_out, 1'b0, "half one runs");
    rd(4'h7, 8'h03, "irq per half");
    wr(4'h7, 8'h03);
    wr(4'h3, 8'h01);
    $display("test overcurrent done");
    wr(4'h0, 8'h00);
    set_state(1'b0);
    @(posedge clk_in);
    overtemp_raw_in <= 1'b1;
    repeat (2010) @(posedge clk_in);
    overtemp_raw_in <= 1'b0;
    wait_cyc(2);
    chk1(out1_hiz_out, 1'b1, "tsd output off");
    chk1(current_sense_hiz_out, 1'b1, "tsd sense off");
    chk1(irq_out, 1'b0, "tsd irq masked");
    rd(4'h6, 8'h16, "standby status tsd");
    wait_cyc(40);
    chk1(out1_hiz_out, 1'b0, "tsd retry");
    chk1(fault_oe_out, 1'b1, "pin follows log");
    rd(4'h4, 8'h05, "summary tsd");
    wr(4'h3, 8'h01);
    wait_cyc(3);
    chk1(fault_oe_out, 1'b0, "tsd cleared");
    $display("test overtemp done");
    wr(4'h0, 8'h01);
    wr(4'h2, 8'h0D);
    wait_cyc(3);
    check({2'b00, olp_setup}, 8'h26, "mirror setup");
    @(posedge clk_in);
    offstate_comparator_in <= 1'b1;
    rd_get(4'h6);
    check(rdv & 8'h09, 8'h09, "comparator bit");
    @(posedge clk_in);
    offstate_comparator_in <= 1'b0;
    ctrl_in2_in <= 1'b1;
    drive_off_in <= 1'b1;
    wr(4'h2, 8'h00);
    wait_cyc(3);
    check({2'b00, olp_setup}, 8'h25, "pin setup");
    for (int c = 1; c >= 0; c--) begin
      @(posedge clk_in);
      offstate_comparator_in <= c[0];
      wait_cyc(3);
      chk1(fault_oe_out, c[0], "locked comparator pin");
    end
    @(posedge clk_in);
    variant_serial_in <= 1'b0;
    hw_offstate_en_in <= 1'b1;
    ctrl_in1_in <= 1'b1;
    offstate_comparator_in <= 1'b1;
    wait_cyc(3);
    check({2'b00, olp_setup}, 8'h19, "hardwired setup");
    chk1(fault_oe_out, 1'b1, "hardwired comparator pin");
    $display("test offstate done");
    give_verdict();
  end
endmodule
`default_nettype wire
